// >>> hdl/psdsp_chain.sv
// Summary of operation
// R01: supply fault aborts serial work until recovery
// R02: four-bit select field chooses self-test mode
// R03: lock bit zeroes select, blocks later writes
// R04: common-mode start sets running, clears fail
// R05: common-mode check repeats every interval
// R06: final fail within one interval, running held
// R07: codes 11xx force sinc output words
// R08: digital or forced modes set running flag
// R09: test modes only selectable before lock
// R10: codes 01xx hold output words fixed
// R11: modulator clocked at 1 MHz, one bit
// R12: two sinc3 stages, 24 then 4
// R13: trim offset, gain, nonlinearity over temperature; only offset and gain have a temperature term, nonlinearity trim does not
// R14: two biquads times a0, 800/1000 Hz
// R15: scaling valid only with zero-cal zero
// R16: 12-bit word: 159 offset, 7 per kPa
// R17: 16-bit word: 28990 offset, 14 per kPa
// R18: SPI 16-bit: 2544 offset, 112 per kPa
// R19: thresholds share the 16-bit word scaling
// R20: one filter sample per 96 modulator clocks
`timescale 1ns/1ps
`default_nettype none
module psdsp_chain
	import psdsp_pkg::*;
#(
	parameter int ST_INTERVAL_US = 1000,
	parameter int CM_LIMIT = 2048,
	parameter int FIFO_DEPTH = 16
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic mod_bit_i,
	input wire logic uv_fault_i,
	input wire logic [3:0] selftest_select_i,
	input wire logic selftest_wr_i,
	input wire logic init_done_lock_i,
	input wire logic filter_1000_i,
	input wire logic [7:0] temp_i,
	input wire logic [15:0] trim_offset_i,
	input wire logic [7:0] trim_offset_tc_i,
	input wire logic [15:0] trim_gain_i,
	input wire logic [7:0] trim_gain_tc_i,
	input wire logic [7:0] trim_nonlin_i,
	input wire logic [15:0] pressure_zero_cal_i,
	input wire logic [15:0] cm_signal_i,
	input wire logic [15:0] thr_high_i,
	input wire logic [15:0] thr_low_i,
	input wire logic fifo_ready_i,
	output logic mod_clk_o,
	output logic serial_enable_o,
	output logic serial_abort_o,
	output logic [3:0] selftest_select_o,
	output logic init_done_lock_o,
	output logic selftest_running_o,
	output logic selftest_fail_o,
	output logic [15:0] sensor_output_word_o,
	output logic [11:0] spi12_pressure_o,
	output logic [15:0] spi16_pressure_o,
	output logic above_high_o,
	output logic below_low_o,
	output logic fifo_valid_o,
	output logic [15:0] fifo_data_o
);
	localparam int ST_CYC = ST_INTERVAL_US * CLK_PER_US;
	localparam int ST_CNT_W = $clog2(ST_CYC);

	// ****************************************************************
	// modulator clock and sinc decimators
	// ****************************************************************
	logic [4:0] div_q, div_d;
	logic mclk_q, mclk_d;
	logic mod_stb;
	logic [1:0] stb_in;
	logic stb_out_q [2];
	logic [15:0] val_in [2];
	logic [15:0] val_out_q [2];

	assign mod_stb = div_q == 5'(MOD_DIV-1);
	assign stb_in = {stb_out_q[0], mod_stb};
	assign val_in[0] = {15'h0000, mod_bit_i};
	assign val_in[1] = val_out_q[0];
	assign mod_clk_o = mclk_q;

	always_comb begin
		div_d = mod_stb ? '0 : div_q + 1'b1;
		mclk_d = mclk_q;
		if (div_q == 5'(MOD_HALF-1) || mod_stb) begin
			mclk_d = !mclk_q; // R11
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			div_q <= '0;
			mclk_q <= 1'b0;
		end else begin
			div_q <= div_d;
			mclk_q <= mclk_d;
		end
	end

	for (genvar s = 0; s < 2; s++) begin : g_sinc
		localparam int RATIO = (s == 0) ? SINC1_RATIO : SINC2_RATIO;
		logic [SINC_W-1:0] integ_q [3];
		logic [SINC_W-1:0] integ_d [3];
		logic [SINC_W-1:0] dly_q [3];
		logic [SINC_W-1:0] dly_d [3];
		logic [SINC_W-1:0] comb [4];
		logic [4:0] cnt_q, cnt_d;
		logic [31:0] prod;
		logic stb_d;
		logic [15:0] val_d;
		logic stb_q;
		logic [15:0] val_q;

		// each stage owns its registers, the shared arrays only carry them
		assign stb_out_q[s] = stb_q;
		assign val_out_q[s] = val_q;

		// wrap-around arithmetic is exact as long as the width covers gain
		always_comb begin
			integ_d = integ_q;
			dly_d = dly_q;
			cnt_d = cnt_q;
			stb_d = 1'b0;
			val_d = val_out_q[s];
			comb[0] = integ_q[2];
			for (int k = 0; k < 3; k++) begin
				comb[k+1] = comb[k] - dly_q[k];
			end
			prod = 32'(comb[3]) * SINC1_RECIP;
			if (stb_in[s]) begin
				integ_d[0] = integ_q[0] + SINC_W'(val_in[s]);
				integ_d[1] = integ_q[1] + integ_q[0];
				integ_d[2] = integ_q[2] + integ_q[1];
				cnt_d = (cnt_q == 5'(RATIO-1)) ? '0 : cnt_q + 1'b1;
				if (cnt_q == 5'(RATIO-1)) begin
					dly_d = comb[0:2];
					stb_d = 1'b1; // R12
					val_d = (s == 0) ? prod[SINC1_NORM_SHIFT +: 16]
						: comb[3][SINC2_NORM_SHIFT +: 16];
				end
			end
		end

		always_ff @(posedge mclk_i) begin
			if (!rst_n_i) begin
				integ_q <= '{default: '0};
				dly_q <= '{default: '0};
				cnt_q <= '0;
				stb_q <= 1'b0;
				val_q <= '0;
			end else begin
				integ_q <= integ_d;
				dly_q <= dly_d;
				cnt_q <= cnt_d;
				stb_q <= stb_d;
				val_q <= val_d;
			end
		end
	end

	// ****************************************************************
	// self-test control and supply monitor
	// ****************************************************************
	logic [3:0] sel_q, sel_d;
	logic lock_q, lock_d;
	logic cm_run_q, cm_run_d, fail_q, fail_d, run_q, run_d;
	logic [ST_CNT_W-1:0] st_cnt_q, st_cnt_d;
	logic en_q, en_d, abort_q, abort_d;
	logic cm_sel, cm_bad, dig_mode, fix_mode;
	logic [15:0] sinc_val;
	logic [16:0] cm_diff;

	assign cm_sel = sel_q == ST_CM;
	assign dig_mode = sel_q[3:2] == ST_DIG_PFX;
	assign fix_mode = sel_q[3:2] == ST_FIX_PFX;
	// forced value replaces the decimator output and bypasses trim and filter
	assign sinc_val = dig_mode ? ST_DIG_WORD[sel_q[1:0]] : val_out_q[1]; // R07
	assign cm_diff = {1'b0, cm_signal_i} - {1'b0, val_out_q[1]};
	assign cm_bad = (cm_diff[16] ? 17'(-cm_diff) : cm_diff) > 17'(CM_LIMIT);

	always_comb begin
		lock_d = lock_q || init_done_lock_i;
		sel_d = sel_q;
		if (lock_d) begin
			sel_d = ST_OFF; // R03 R09
		end else if (selftest_wr_i) begin
			sel_d = selftest_select_i; // R02
		end
		cm_run_d = cm_run_q;
		fail_d = fail_q;
		st_cnt_d = st_cnt_q;
		if (!cm_run_q && cm_sel) begin
			cm_run_d = 1'b1; // R04
			fail_d = 1'b0;
			st_cnt_d = '0;
		end else if (cm_run_q) begin
			if (st_cnt_q == ST_CNT_W'(ST_CYC-1)) begin
				st_cnt_d = '0; // R05
				fail_d = cm_bad;
				cm_run_d = cm_sel; // R06
			end else begin
				st_cnt_d = st_cnt_q + 1'b1;
			end
		end
		run_d = cm_run_d || sel_d[2]; // R08
		en_d = !uv_fault_i;
		abort_d = uv_fault_i && en_q; // R01
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			sel_q <= ST_OFF;
			lock_q <= 1'b0;
			cm_run_q <= 1'b0;
			fail_q <= 1'b0;
			run_q <= 1'b0;
			st_cnt_q <= '0;
			en_q <= 1'b0;
			abort_q <= 1'b0;
		end else begin
			sel_q <= sel_d;
			lock_q <= lock_d;
			cm_run_q <= cm_run_d;
			fail_q <= fail_d;
			run_q <= run_d;
			st_cnt_q <= st_cnt_d;
			en_q <= en_d;
			abort_q <= abort_d;
		end
	end

	assign selftest_select_o = sel_q;
	assign init_done_lock_o = lock_q;
	assign selftest_running_o = run_q;
	assign selftest_fail_o = fail_q;
	assign serial_enable_o = en_q;
	assign serial_abort_o = abort_q;

	// ****************************************************************
	// trim, iir low-pass and output words
	// ****************************************************************
	typedef enum logic [2:0] {DSP_IDLE, DSP_TRIM, DSP_SEC1, DSP_SEC2,
		DSP_OUT} psdsp_state_t;
	psdsp_state_t dsp_q, dsp_d;
	logic signed [31:0] acc_q, acc_d;
	logic signed [31:0] xh_q [2][2], xh_d [2][2], yh_q [2][2], yh_d [2][2];
	logic [15:0] word_q, word_d, s16_q, s16_d;
	logic [11:0] s12_q, s12_d;
	logic hi_q, hi_d, lo_q, lo_d, push_q, push_d;
	logic [15:0] push_data_q, push_data_d;
	logic fifo_in_ready;
	logic signed [31:0] t_dt, t_off, t_gain, t_x, t_cen, t_nl, t_trim, t_y;
	logic signed [31:0] v_out, v12, v16, v_diff;
	logic signed [63:0] t_prod;
	int sec;

	function automatic logic signed [31:0] biquad(
		input logic signed [31:0] x, x1, x2, y1, y2,
		input logic [COEF_W-1:0] n0, n1, n2, d1, d2);
		logic signed [63:0] s;
		s = 64'(x) * 64'($signed(n0)) + 64'(x1) * 64'($signed(n1))
			+ 64'(x2) * 64'($signed(n2)) - 64'(y1) * 64'($signed(d1))
			- 64'(y2) * 64'($signed(d2));
		return 32'(s >>> COEF_FRAC);
	endfunction : biquad

	function automatic logic [15:0] sat(input logic signed [31:0] v,
		input logic signed [31:0] top);
		sat = (v < 0) ? 16'h0000 : (v > top) ? 16'(top) : 16'(v);
	endfunction : sat

	always_comb begin
		dsp_d = dsp_q;
		acc_d = acc_q;
		xh_d = xh_q;
		yh_d = yh_q;
		word_d = word_q;
		push_d = push_q && !fifo_in_ready;
		push_data_d = push_data_q;
		sec = (dsp_q == DSP_SEC2) ? 1 : 0;
		t_dt = 32'($signed({1'b0, temp_i})) - 32'($signed({1'b0, TEMP_ZERO_LSB}));
		t_off = 32'($signed(trim_offset_i))
			+ 32'($signed(trim_offset_tc_i)) * t_dt;
		t_gain = 32'($signed(trim_gain_i)) + 32'($signed(trim_gain_tc_i)) * t_dt;
		t_x = 32'($signed({1'b0, acc_q[15:0]}));
		t_cen = t_x - 32'sh0000_8000;
		t_nl = ((t_cen * t_cen) >>> 16) * 32'($signed(trim_nonlin_i)) >>> 8;
		t_prod = 64'(t_x) * 64'(t_gain);
		t_trim = 32'(t_prod >>> GAIN_FRAC) + t_off + t_nl; // R13
		t_prod = 64'(t_trim)
			* 64'($signed(IIR_COEF[filter_1000_i][C_A0])); // R14
		t_y = biquad(acc_q, xh_q[sec][0], xh_q[sec][1], yh_q[sec][0],
			yh_q[sec][1], IIR_COEF[filter_1000_i][1+C_SEC*sec],
			IIR_COEF[filter_1000_i][2+C_SEC*sec],
			IIR_COEF[filter_1000_i][3+C_SEC*sec],
			IIR_COEF[filter_1000_i][4+C_SEC*sec],
			IIR_COEF[filter_1000_i][5+C_SEC*sec]);
		// zero-cal shifts the word, the scaling figures assume it is zero
		v_out = acc_q - 32'(pressure_zero_cal_i); // R15
		case (dsp_q)
			DSP_IDLE: begin
				if (stb_out_q[1]) begin
					acc_d = 32'(sinc_val); // R20
					dsp_d = DSP_TRIM;
				end
			end
			DSP_TRIM: begin
				// self-test values skip trim and filter so the word is exact
				acc_d = dig_mode ? acc_q : 32'(t_prod >>> COEF_FRAC);
				dsp_d = dig_mode ? DSP_OUT : DSP_SEC1;
			end
			DSP_SEC1, DSP_SEC2: begin
				xh_d[sec][0] = acc_q; // R14
				xh_d[sec][1] = xh_q[sec][0];
				yh_d[sec][0] = t_y;
				yh_d[sec][1] = yh_q[sec][0];
				acc_d = t_y;
				dsp_d = (dsp_q == DSP_SEC1) ? DSP_SEC2 : DSP_OUT;
			end
			DSP_OUT: begin
				if (!fix_mode) begin
					word_d = dig_mode ? 16'(acc_q) : sat(v_out, 32'h0000_FFFF);
					push_d = 1'b1;
					push_data_d = word_d;
				end
				dsp_d = DSP_IDLE;
			end
			default: dsp_d = DSP_IDLE;
		endcase
		if (fix_mode) begin
			word_d = ST_FIX_WORD[sel_q[1:0]]; // R10
		end
		// kept signed throughout so a word more than 318 below the offset clips to zero
		v_diff = $signed(32'(word_d)) - $signed(32'(P16_OFFSET)); // R17
		v12 = (v_diff >>> P12_SHIFT) + $signed(32'(P12_OFFSET)); // R16
		v16 = (v_diff <<< PS16_SHIFT) + $signed(32'(PS16_OFFSET)); // R18
		s12_d = 12'(sat(v12, 32'h0000_0FFF));
		s16_d = sat(v16, 32'h0000_FFFF);
		hi_d = word_d > thr_high_i; // R19
		lo_d = word_d < thr_low_i;
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			dsp_q <= DSP_IDLE;
			acc_q <= '0;
			xh_q <= '{default: '0};
			yh_q <= '{default: '0};
			word_q <= '0;
			s12_q <= '0;
			s16_q <= '0;
			hi_q <= 1'b0;
			lo_q <= 1'b0;
			push_q <= 1'b0;
			push_data_q <= '0;
		end else begin
			dsp_q <= dsp_d;
			acc_q <= acc_d;
			xh_q <= xh_d;
			yh_q <= yh_d;
			word_q <= word_d;
			s12_q <= s12_d;
			s16_q <= s16_d;
			hi_q <= hi_d;
			lo_q <= lo_d;
			push_q <= push_d;
			push_data_q <= push_data_d;
		end
	end

	assign sensor_output_word_o = word_q;
	assign spi12_pressure_o = s12_q;
	assign spi16_pressure_o = s16_q;
	assign above_high_o = hi_q;
	assign below_low_o = lo_q;

	// a full fifo keeps the pending word, a newer sample replaces it
	psdsp_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(push_q),
		.in_data_i(push_data_q),
		.in_ready_o(fifo_in_ready),
		.out_valid_o(fifo_valid_o),
		.out_data_o(fifo_data_o),
		.out_ready_i(fifo_ready_i)
	);

	// ****************************************************************
	// checks
	// ****************************************************************
	logic [11:0] gap_q;
	logic seen_q;
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			gap_q <= '0;
			seen_q <= 1'b0;
		end else begin
			gap_q <= stb_out_q[1] ? '0 : gap_q + 1'b1;
			seen_q <= seen_q || stb_out_q[1];
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_dig_sample;
		dig_mode && stb_out_q[1] && dsp_q == DSP_IDLE;
	endsequence
	sequence s_dig_hold;
		(dig_mode && $stable(sel_q))[*2];
	endsequence

	a_uv_abort: assert property ($rose(uv_fault_i) && en_q |=> // R01
		serial_abort_o && !serial_enable_o ##1 !serial_abort_o)
		else $error("supply fault did not abort serial work");
	a_lock_zero_sel: assert property (lock_q |-> sel_q == ST_OFF) // R03
		else $error("select field not zero after lock");
	a_lock_no_write: assert property (lock_q && selftest_wr_i // R09
		|=> !dig_mode && !fix_mode && !cm_sel)
		else $error("test mode entered after lock");
	a_cm_start: assert property (!cm_run_q && cm_sel // R04
		|=> selftest_running_o && !selftest_fail_o && st_cnt_q == '0)
		else $error("common-mode start flags wrong");
	a_cm_repeat: assert property (cm_run_q && cm_sel // R05
		&& st_cnt_q == ST_CNT_W'(ST_CYC-1) |=> cm_run_q && st_cnt_q == '0)
		else $error("common-mode check did not repeat");
	a_cm_final: assert property ($fell(cm_run_q) |-> // R06
		$past(st_cnt_q) == ST_CNT_W'(ST_CYC-1) && fail_q == $past(cm_bad))
		else $error("final common-mode result not reported");
	a_dig_word: assert property (s_dig_sample ##1 s_dig_hold |=> // R07
		sensor_output_word_o == ST_DIG_WORD[sel_q[1:0]])
		else $error("digital self-test word wrong");
	a_run_modes: assert property (sel_q[2] |-> selftest_running_o) // R08
		else $error("running flag low in a test mode");
	a_fix_hold: assert property (fix_mode ##1 fix_mode |-> // R10
		sensor_output_word_o == ST_FIX_WORD[$past(sel_q[1:0])])
		else $error("fixed output word not held");
	a_mod_clk: assert property ($changed(mod_clk_o) |=> // R11
		$stable(mod_clk_o)[*8] ##1 $stable(mod_clk_o) ##1 $changed(mod_clk_o))
		else $error("modulator clock not 1 MHz");
	a_decim_gap: assert property (stb_out_q[1] && seen_q |-> // R12 R20
		gap_q == 12'(DECIM_CYC-1))
		else $error("filter sample spacing not 96 modulator clocks");
	a_spi12_map: assert property (word_q == P16_OFFSET |-> ##1 // R16
		$past(word_d) != P16_OFFSET || spi12_pressure_o == 12'(P12_OFFSET))
		else $error("12-bit zero-pressure code wrong");
endmodule : psdsp_chain
`default_nettype wire

// >>> hdl/psdsp_pkg.sv
package psdsp_pkg;
	// ****************************************************************
	// clocking and modulator
	// ****************************************************************
	localparam int CLK_HZ = 20_000_000;
	localparam int MOD_HZ = 1_000_000;
	localparam int MOD_DIV = CLK_HZ / MOD_HZ;
	localparam int MOD_HALF = MOD_DIV / 2;
	localparam int US_PER_S = 1_000_000;
	localparam int CLK_PER_US = CLK_HZ / US_PER_S;

	// ****************************************************************
	// sinc decimators
	// ****************************************************************
	localparam int SINC1_RATIO = 24;
	localparam int SINC2_RATIO = 4;
	localparam int SINC_W = 22;
	localparam int DECIM_CYC = SINC1_RATIO * SINC2_RATIO * MOD_DIV;
	// 2^30 / 24^3, so the first stage lands on a 16-bit full scale
	localparam logic [31:0] SINC1_RECIP = 32'h0001_2F68;
	localparam int SINC1_NORM_SHIFT = 14;
	// 4^3 is a power of two, a shift is exact
	localparam int SINC2_NORM_SHIFT = 6;

	// ****************************************************************
	// self-test select codes
	// ****************************************************************
	localparam logic [3:0] ST_OFF = 4'h0;
	localparam logic [3:0] ST_CM = 4'h1;
	localparam logic [1:0] ST_DIG_PFX = 2'h3;
	localparam logic [1:0] ST_FIX_PFX = 2'h1;
	localparam logic [15:0] ST_DIG_WORD [4] = '{16'h8171, 16'h6C95,
		16'h807A, 16'h78AC};
	localparam logic [15:0] ST_FIX_WORD [4] = '{16'h0000, 16'hAAAA,
		16'h5555, 16'hFFFF};

	// ****************************************************************
	// trim and iir, coefficients signed q2.22, negatives two's complement
	// ****************************************************************
	localparam logic [7:0] TEMP_ZERO_LSB = 8'h44;
	localparam int GAIN_FRAC = 14;
	localparam int COEF_W = 24;
	localparam int COEF_FRAC = 22;
	localparam int C_A0 = 0;
	localparam int C_SEC = 5;
	localparam logic [COEF_W-1:0] IIR_COEF [2][11] = '{
		'{24'h05_AC52,
		  24'h01_E597, 24'h05_9A4F, 24'h01_E687, 24'hA4_F0F7, 24'h20_BB5B,
		  24'h10_03F4, 24'h1F_FFFF, 24'h0F_FC0D, 24'h9F_C971, 24'h27_CECB},
		'{24'h08_4B70,
		  24'h02_CC4E, 24'h05_9A4F, 24'h02_CE02, 24'hAC_C491, 24'h1B_86DF,
		  24'h10_04DC, 24'h1F_FFFF, 24'h0F_FB26, 24'hA7_AEBE, 24'h23_85E1}};

	// ****************************************************************
	// output scaling and register map of the words
	// ****************************************************************
	localparam logic [15:0] P16_OFFSET = 16'h713E;
	localparam int P16_SENSE = 14;
	localparam logic [15:0] P12_OFFSET = 16'h009F;
	localparam int P12_SENSE = 7;
	localparam logic [15:0] PS16_OFFSET = 16'h09F0;
	localparam int PS16_SENSE = 112;
	localparam int P12_SHIFT = $clog2(P16_SENSE / P12_SENSE);
	localparam int PS16_SHIFT = $clog2(PS16_SENSE / P16_SENSE);
	localparam logic [7:0] REG_PRESS_HI = 8'h62;
	localparam logic [7:0] REG_PRESS_LO = 8'h63;
	localparam logic [7:0] REG_THR_FIRST = 8'h46;
	localparam logic [7:0] REG_THR_LAST = 8'h49;
endpackage : psdsp_pkg

// >>> hdl/psdsp_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module psdsp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;

	assign in_ready_o = cnt_q != (AW+1)'(DEPTH);
	assign out_valid_o = cnt_q != '0;
	assign out_data_o = mem_q[rd_q];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_comb begin
		mem_d = mem_q;
		wr_d = wr_q;
		rd_d = rd_q;
		cnt_d = cnt_q;
		if (push) begin
			mem_d[wr_q] = in_data_i;
			wr_d = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
		end
		if (pop) begin
			rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
		end
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		mem_q <= mem_d;
		if (!rst_n_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	a_fifo_full_stall: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		cnt_q == (AW+1)'(DEPTH) |-> !in_ready_o)
		else $error("fifo accepts while full");
	a_fifo_count_step: assert property (@(posedge clk_i)
		disable iff (!rst_n_i)
		push && !pop |=> cnt_q == $past(cnt_q) + 1'b1)
		else $error("fifo count did not follow a push");
endmodule : psdsp_fifo
`default_nettype wire

// >>> testbench/psdsp_mod_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// modulator stand-in
// ****************************************************************
// first-order accumulator in place of the analog loop: the share of ones
// follows density_i, and a density of zero gives a stream of zeros
module psdsp_mod_model (
	input wire logic mod_clk_i,
	input wire logic [15:0] density_i,
	output logic mod_bit_o
);
	logic [15:0] acc_q;
	logic [16:0] sum;

	assign sum = {1'b0, acc_q} + {1'b0, density_i};

	initial begin
		acc_q = 16'h0000;
		mod_bit_o = 1'b0;
	end

	// one bit per modulator clock, changed just after its rising edge
	always @(posedge mod_clk_i) begin
		acc_q <= sum[15:0];
		mod_bit_o <= sum[16];
	end
endmodule : psdsp_mod_model
`default_nettype wire

// >>> testbench/psdsp_chain_tb.sv
`timescale 1ns/1ps
`default_nettype none
module psdsp_chain_tb;
	import psdsp_pkg::*;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic mod_bit, uv = 1'b0, st_wr = 1'b0, lock = 1'b0, flt = 1'b0;
	logic ready = 1'b1;
	logic [3:0] st_sel = 4'h0;
	logic [7:0] temp = 8'h44, ofs_tc = 8'h00, gain_tc = 8'h00, nonlin = 8'h00;
	logic [15:0] ofs = 16'h0000, gain = 16'h4000, cm = 16'hFFFF;
	logic [15:0] thr_hi = 16'h0000, thr_lo = 16'h0000, density = 16'h0000;
	logic mod_clk, ser_en, ser_abort, lock_o, running, fail, above, below;
	logic valid;
	logic [3:0] sel_o;
	logic [15:0] word, spi16, fdata;
	logic [11:0] spi12;
	logic [15:0] exp_q [$];
	int fail_count = 0;
	int checked = 0;
	int cyc = 0;
	int pops = 0;
	int n;
	logic [15:0] fix [4] = '{16'h0000, 16'hAAAA, 16'h5555, 16'hFFFF};
	logic [15:0] dig [4] = '{16'h8171, 16'h6C95, 16'h807A, 16'h78AC};

	always #25 mclk_i = ~mclk_i;

	psdsp_mod_model u_mod (.mod_clk_i(mod_clk), .density_i(density),
		.mod_bit_o(mod_bit));

	// short interval keeps each common-mode round at 100 clocks
	psdsp_chain #(.ST_INTERVAL_US(5)) DUT (.mclk_i(mclk_i),
		.rst_n_i(rst_n_i), .mod_bit_i(mod_bit), .uv_fault_i(uv),
		.selftest_select_i(st_sel), .selftest_wr_i(st_wr),
		.init_done_lock_i(lock), .filter_1000_i(flt), .temp_i(temp),
		.trim_offset_i(ofs), .trim_offset_tc_i(ofs_tc), .trim_gain_i(gain),
		.trim_gain_tc_i(gain_tc), .trim_nonlin_i(nonlin),
		.pressure_zero_cal_i(16'h0000), .cm_signal_i(cm),
		.thr_high_i(thr_hi), .thr_low_i(thr_lo), .fifo_ready_i(ready),
		.mod_clk_o(mod_clk), .serial_enable_o(ser_en),
		.serial_abort_o(ser_abort), .selftest_select_o(sel_o),
		.init_done_lock_o(lock_o), .selftest_running_o(running),
		.selftest_fail_o(fail), .sensor_output_word_o(word),
		.spi12_pressure_o(spi12), .spi16_pressure_o(spi16),
		.above_high_o(above), .below_low_o(below), .fifo_valid_o(valid),
		.fifo_data_o(fdata));

	// ****************************************************************
	// comparison and closing
	// ****************************************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check

	task automatic complete_run;
		$display("checked %0d, fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run

	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 90000) begin
			fail_count++;
			complete_run;
		end
	end

	// looks 5 ns before each rising edge, when a pop is settled
	always @(negedge mclk_i) begin
		#20;
		if (valid === 1'b1 && ready === 1'b1) begin
			pops++;
			if (exp_q.size() > 0)
				check(fdata, exp_q.pop_front());
		end
	end

	// ****************************************************************
	// stimulus helpers
	// ****************************************************************
	task automatic write_sel(input logic [3:0] code);
		@(negedge mclk_i);
		st_sel = code;
		st_wr = 1'b1;
		@(negedge mclk_i);
		st_wr = 1'b0;
	endtask : write_sel

	task automatic idle(input int cycles);
		repeat (cycles) @(negedge mclk_i);
	endtask : idle

	function automatic logic [15:0] exp12(input logic [15:0] w);
		int v;
		v = ((int'(w) - 28990) >>> 1) + 159;
		return (v < 0) ? 16'h0000 : (v > 4095) ? 16'h0FFF : 16'(v);
	endfunction : exp12

	function automatic logic [15:0] exp16(input logic [15:0] w);
		int v;
		v = ((int'(w) - 28990) <<< 3) + 2544;
		return (v < 0) ? 16'h0000 : (v > 65535) ? 16'hFFFF : 16'(v);
	endfunction : exp16

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		void'($urandom(20574));
		flt = 1'($urandom);
		temp = 8'($urandom);
		ofs = 16'($urandom);
		nonlin = 8'($urandom);
		idle(16);
		rst_n_i = 1'b1;
		idle(2);
		check(sel_o, 16'h0000);
		check(lock_o, 16'h0000);
		check(ser_en, 16'h0001);
		uv = 1'b1;
		idle(1);
		check(ser_en, 16'h0000);
		check(ser_abort, 16'h0001);
		idle(1);
		check(ser_abort, 16'h0000);
		uv = 1'b0;
		idle(1);
		check(ser_en, 16'h0001);
		// zero-density stream settles the decimator before the cm round
		idle(2 * DECIM_CYC + 40);
		write_sel(4'h1);
		idle(1);
		check(running, 16'h0001);
		idle(105);
		check(fail, 16'h0001);
		cm = 16'h0000;
		idle(105);
		check(fail, 16'h0000);
		cm = 16'hFFFF;
		write_sel(4'h0);
		check(running, 16'h0001);
		for (n = 0; running === 1'b1 && n < 110; n++)
			@(negedge mclk_i);
		check(16'(n <= 101), 16'h0001);
		check(fail, 16'h0001);
		cm = 16'h0000;
		write_sel(4'h1);
		idle(1);
		check(fail, 16'h0000);
		write_sel(4'h0);
		idle(110);
		for (int k = 0; k < 4; k++) begin
			write_sel({2'b01, 2'(k)});
			idle(2);
			check(sel_o, {2'b01, 2'(k)});
			check(word, fix[k]);
			check(running, 16'h0001);
		end
		for (int k = 0; k < 4; k++) begin
			thr_hi = 16'($urandom);
			thr_lo = 16'($urandom);
			write_sel({2'b11, 2'(k)});
			idle(2 * DECIM_CYC + 40);
			check(word, dig[k]);
			check(running, 16'h0001);
			check(16'(spi12), exp12(dig[k]));
			check(spi16, exp16(dig[k]));
			check(16'(above), 16'(dig[k] > thr_hi));
			check(16'(below), 16'(dig[k] < thr_lo));
		end
		// fill the buffer past its depth while the sink stalls
		write_sel(4'hC);
		idle(2 * DECIM_CYC + 40);
		ready = 1'b0;
		// sixteen stored words plus the one held pending at the input
		repeat (17) exp_q.push_back(16'h8171);
		idle(17 * DECIM_CYC + 40);
		write_sel(4'h4);
		pops = 0;
		repeat (400) begin
			@(negedge mclk_i);
			ready = 1'($urandom);
		end
		ready = 1'b1;
		idle(2);
		check(16'(pops), 16'h0011);
		check(16'(exp_q.size()), 16'h0000);
		check(valid, 16'h0000);
		write_sel(4'h5);
		lock = 1'b1;
		idle(1);
		lock = 1'b0;
		check(lock_o, 16'h0001);
		check(sel_o, 16'h0000);
		write_sel(4'hC);
		idle(3);
		check(sel_o, 16'h0000);
		check(running, 16'h0000);
		rst_n_i = 1'b0;
		idle(16);
		rst_n_i = 1'b1;
		idle(1);
		check(lock_o, 16'h0000);
		write_sel(4'h6);
		check(sel_o, 16'h0006);
		complete_run;
	end
endmodule : psdsp_chain_tb
`default_nettype wire
